/* hdl/i2c_master_pkg.sv */
// package for the single-master two-wire controller: states, widths, counts
// assumes one peripheral clock; the bit clock arrives as a one-cycle tick
package i2c_master_pkg;

  // peripheral clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;

  // supported bus rates; the real rate follows the tick frequency
  localparam int STD_RATE_BPS = 100000;
  localparam int FAST_RATE_BPS = 400000;
  localparam int TICKS_PER_BIT = 2;
  localparam int STD_TICK_CYCLES = CLK_HZ / (STD_RATE_BPS * TICKS_PER_BIT);
  localparam int FAST_TICK_CYCLES = CLK_HZ / (FAST_RATE_BPS * TICKS_PER_BIT);

  // byte framing
  localparam int BYTE_W = 8;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [3:0] CNT_D6 = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam int MSB = BYTE_W - 1;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // input glitch filter: a new level must hold this many cycles
  localparam int FILTER_LEN = 3;
  localparam logic [1:0] FILTER_LAST = 2'(FILTER_LEN - 1);
  localparam logic [1:0] FILTER_ZERO = 2'h0;
  localparam logic [1:0] FILTER_ONE = 2'h1;

  // pin index inside the synchroniser array
  localparam int PIN_SDA = 0;
  localparam int PIN_SCL = 1;
  localparam int PIN_COUNT = 2;

  // two-entry buffer
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] BUF_FULL = 2'h2;
  localparam logic [1:0] BUF_EMPTY = 2'h0;
  localparam logic [1:0] BUF_ONE = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START_HOLD = 3'b001,
    ST_LOAD = 3'b010,
    ST_SHIFT = 3'b011,
    ST_WAIT = 3'b100,
    ST_STOP_RISE = 3'b101,
    ST_STOP_END = 3'b110
  } bus_state_e;

endpackage

/* hdl/byte_stream_if.sv */
// byte stream carrier with valid and ready between the controller's modules
// assumes source and sink share the peripheral clock
`timescale 1ns/1ns
`default_nettype none
interface byte_stream_if;
  logic [7:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

/* hdl/two_entry_buffer.sv */
// two-entry buffer for received bytes, flip-flop storage, valid and ready on both sides
// assumes the upstream pushes only when ready is high
`timescale 1ns/1ns
`default_nettype none
module two_entry_buffer (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // streams
  byte_stream_if.snk up,
  byte_stream_if.src down
);

  logic [7:0] mem_reg [i2c_master_pkg::BUF_DEPTH];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  assign up.ready = (count_reg != i2c_master_pkg::BUF_FULL);
  assign down.valid = (count_reg != i2c_master_pkg::BUF_EMPTY);
  assign down.data = mem_reg[rd_ptr_reg];
  assign push = up.valid && up.ready;
  assign pop = down.valid && down.ready;

  genvar i;
  generate
    for (i = 0; i < i2c_master_pkg::BUF_DEPTH; i++) begin : g_entry
      always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          mem_reg[i] <= i2c_master_pkg::BYTE_RESET;
        end else if (push && (wr_ptr_reg == 1'(i))) begin
          mem_reg[i] <= up.data;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= i2c_master_pkg::BUF_EMPTY;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + i2c_master_pkg::BUF_ONE;
      end else if (pop && !push) begin
        count_reg <= count_reg - i2c_master_pkg::BUF_ONE;
      end
    end
  end

endmodule
`default_nettype wire

/* hdl/i2c_master_start_transmit.sv */
// single-master two-wire bus controller: start, byte send and receive, ack, stop, wait
// assumes the bit clock arrives as a one-cycle tick on the peripheral clock and
// that the open-drain pins are resolved outside from the output enables
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - master only, clock from timer ticks
// - bit rate follows the tick frequency
// - no clock stretching, clock never waits
// - clock pin only observed, never shifts
// - filter on: deglitch both bus inputs
// - enable readies controller, allows clock output
// - start: data falls while clock high
// - start request self-clears after start
// - transmit waits for start or byte
// - byte load: clock runs, clears, empty event
// - transmit bits change on falling edge, MSB first
// - nine clocks, data released in ninth
// - ninth-clock low is ack, high nack
// - transmit busy from load to end/wait
// - ack status shows last transmit answer
// - stop after byte, data rises, self-clears
// - no repeated start; stop comes first
// - idle flags after byte hold clock low
// - receive MSB first on rise, answer from ack status
module i2c_master_start_transmit (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // configuration and bit clock
  input wire logic module_enable_in,
  input wire logic noise_filter_on_in,
  input wire logic timer_tick_in,
  // software requests, one-cycle set pulses
  input wire logic start_request_set_in,
  input wire logic stop_request_set_in,
  input wire logic transmit_execute_set_in,
  input wire logic [7:0] shift_data_byte_in,
  input wire logic receive_execute_set_in,
  input wire logic ack_status_write_in,
  input wire logic ack_status_in,
  // status
  output logic start_request_out,
  output logic stop_request_out,
  output logic transmit_execute_out,
  output logic receive_execute_out,
  output logic transmit_in_progress_out,
  output logic receive_in_progress_out,
  output logic ack_status_out,
  output logic tx_buffer_empty_out,
  output logic bus_clock_level_out,
  output logic bus_data_level_out,
  // received bytes
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  // bus pins
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out
);

  // pin synchronisers and glitch filters
  logic pin_raw [i2c_master_pkg::PIN_COUNT];
  logic meta_reg [i2c_master_pkg::PIN_COUNT];
  logic sync_reg [i2c_master_pkg::PIN_COUNT];
  logic filt_reg [i2c_master_pkg::PIN_COUNT];
  logic [1:0] filt_cnt_reg [i2c_master_pkg::PIN_COUNT];
  logic sda_level;

  assign pin_raw[i2c_master_pkg::PIN_SDA] = sda_in;
  assign pin_raw[i2c_master_pkg::PIN_SCL] = scl_in;

  genvar p;
  generate
    for (p = 0; p < i2c_master_pkg::PIN_COUNT; p++) begin : g_pin
      always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          meta_reg[p] <= 1'b1;
          sync_reg[p] <= 1'b1;
        end else begin
          meta_reg[p] <= pin_raw[p];
          sync_reg[p] <= meta_reg[p];
        end
      end

      // a filtered level changes only after the new level has held long enough
      always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          filt_reg[p] <= 1'b1;
          filt_cnt_reg[p] <= i2c_master_pkg::FILTER_ZERO;
        end else if (!noise_filter_on_in) begin
          filt_reg[p] <= sync_reg[p];
          filt_cnt_reg[p] <= i2c_master_pkg::FILTER_ZERO;
        end else if (sync_reg[p] == filt_reg[p]) begin
          filt_cnt_reg[p] <= i2c_master_pkg::FILTER_ZERO;
        end else if (filt_cnt_reg[p] == i2c_master_pkg::FILTER_LAST) begin
          filt_reg[p] <= sync_reg[p];
          filt_cnt_reg[p] <= i2c_master_pkg::FILTER_ZERO;
        end else begin
          filt_cnt_reg[p] <= filt_cnt_reg[p] + i2c_master_pkg::FILTER_ONE;
        end
      end
    end
  endgenerate

  assign sda_level = filt_reg[i2c_master_pkg::PIN_SDA];

  // received byte buffer
  byte_stream_if rx_in ();
  byte_stream_if rx_out ();

  two_entry_buffer u_rx_buffer (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .up(rx_in.snk),
    .down(rx_out.src)
  );

  assign rx_data_out = rx_out.data;
  assign rx_valid_out = rx_out.valid;
  assign rx_out.ready = rx_ready_in;

  // state
  i2c_master_pkg::bus_state_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_data_reg;
  logic is_rx_reg;
  logic sda_low_reg;
  logic scl_low_reg;
  logic start_request_reg;
  logic stp_reg;
  logic txe_reg;
  logic rxe_reg;
  logic transmit_in_progress_reg;
  logic rbusy_reg;
  logic ack_reg;
  logic tx_empty_reg;

  // events of this cycle
  logic tick;
  logic load_go;
  logic take_tx;
  logic take_rx;
  logic take_stop;
  logic go_wait;
  logic start_done;
  logic stop_done;
  logic rise;
  logic fall;
  logic byte_done;
  logic ack_sample;
  logic rxe_clear;

  always_comb begin
    tick = timer_tick_in && module_enable_in;
    load_go = (state_reg == i2c_master_pkg::ST_LOAD) && tick;
    take_tx = load_go && txe_reg;
    take_rx = load_go && !txe_reg && rxe_reg && rx_in.ready;
    take_stop = load_go && !txe_reg && !rxe_reg && stp_reg;
    go_wait = load_go && !txe_reg && !rxe_reg && !stp_reg && !start_request_reg;
    start_done = (state_reg == i2c_master_pkg::ST_START_HOLD) && tick;
    stop_done = (state_reg == i2c_master_pkg::ST_STOP_END) && tick;
    rise = (state_reg == i2c_master_pkg::ST_SHIFT) && tick && scl_low_reg;
    fall = (state_reg == i2c_master_pkg::ST_SHIFT) && tick && !scl_low_reg;
    byte_done = fall && (bit_cnt_reg == i2c_master_pkg::CNT_ACK);
    ack_sample = rise && !is_rx_reg && (bit_cnt_reg == i2c_master_pkg::CNT_ACK);
    rxe_clear = rise && is_rx_reg && (bit_cnt_reg == i2c_master_pkg::CNT_D6);
  end

  // bus sequencer; the clock never waits on the pin, so stretching slaves break it
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= i2c_master_pkg::ST_IDLE;
      bit_cnt_reg <= i2c_master_pkg::CNT_ZERO;
      shift_reg <= i2c_master_pkg::BYTE_RESET;
      is_rx_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      scl_low_reg <= 1'b0;
    end else if (!module_enable_in) begin
      state_reg <= i2c_master_pkg::ST_IDLE;
      sda_low_reg <= 1'b0;
      scl_low_reg <= 1'b0;
    end else begin
      case (state_reg)
        i2c_master_pkg::ST_IDLE: begin
          // a start is only made from a free bus, never repeated
          if (tick && start_request_reg) begin
            sda_low_reg <= 1'b1;
            state_reg <= i2c_master_pkg::ST_START_HOLD;
          end
        end
        i2c_master_pkg::ST_START_HOLD: begin
          if (tick) begin
            scl_low_reg <= 1'b1;
            state_reg <= i2c_master_pkg::ST_LOAD;
          end
        end
        i2c_master_pkg::ST_LOAD: begin
          if (take_tx) begin
            shift_reg <= tx_data_reg;
            sda_low_reg <= ~tx_data_reg[i2c_master_pkg::MSB];
            bit_cnt_reg <= i2c_master_pkg::CNT_ZERO;
            is_rx_reg <= 1'b0;
            state_reg <= i2c_master_pkg::ST_SHIFT;
          end else if (take_rx) begin
            sda_low_reg <= 1'b0;
            bit_cnt_reg <= i2c_master_pkg::CNT_ZERO;
            is_rx_reg <= 1'b1;
            state_reg <= i2c_master_pkg::ST_SHIFT;
          end else if (take_stop) begin
            sda_low_reg <= 1'b1;
            state_reg <= i2c_master_pkg::ST_STOP_RISE;
          end else if (go_wait) begin
            state_reg <= i2c_master_pkg::ST_WAIT;
          end
        end
        i2c_master_pkg::ST_WAIT: begin
          // clock stays low until software asks for more
          if (txe_reg || rxe_reg || stp_reg) begin
            state_reg <= i2c_master_pkg::ST_LOAD;
          end
        end
        i2c_master_pkg::ST_SHIFT: begin
          if (rise) begin
            scl_low_reg <= 1'b0;
            if (is_rx_reg && (bit_cnt_reg != i2c_master_pkg::CNT_ACK)) begin
              shift_reg <= {shift_reg[6:0], sda_level};
            end
          end else if (fall) begin
            scl_low_reg <= 1'b1;
            if (byte_done) begin
              sda_low_reg <= 1'b0;
              state_reg <= i2c_master_pkg::ST_LOAD;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + i2c_master_pkg::CNT_ONE;
              if (bit_cnt_reg == (i2c_master_pkg::CNT_ACK - i2c_master_pkg::CNT_ONE)) begin
                sda_low_reg <= is_rx_reg && !ack_reg;
              end else if (!is_rx_reg) begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                sda_low_reg <= ~shift_reg[i2c_master_pkg::MSB - 1];
              end
            end
          end
        end
        i2c_master_pkg::ST_STOP_RISE: begin
          if (tick) begin
            scl_low_reg <= 1'b0;
            state_reg <= i2c_master_pkg::ST_STOP_END;
          end
        end
        i2c_master_pkg::ST_STOP_END: begin
          if (tick) begin
            sda_low_reg <= 1'b0;
            state_reg <= i2c_master_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= i2c_master_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // a received byte goes to the buffer as the ninth clock ends; a receive is
  // only begun while the buffer has room, so the push is never refused
  assign rx_in.data = shift_reg;
  assign rx_in.valid = byte_done && is_rx_reg;

  // start request: software set wins over the self-clear
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      start_request_reg <= 1'b0;
    end else if (!module_enable_in) begin
      start_request_reg <= 1'b0;
    end else if (start_request_set_in) begin
      start_request_reg <= 1'b1;
    end else if (start_done) begin
      start_request_reg <= 1'b0;
    end
  end

  // stop request
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stp_reg <= 1'b0;
    end else if (!module_enable_in) begin
      stp_reg <= 1'b0;
    end else if (stop_request_set_in) begin
      stp_reg <= 1'b1;
    end else if (stop_done) begin
      stp_reg <= 1'b0;
    end
  end

  // transmit execute with its data byte
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      txe_reg <= 1'b0;
      tx_data_reg <= i2c_master_pkg::BYTE_RESET;
    end else if (!module_enable_in) begin
      txe_reg <= 1'b0;
    end else if (transmit_execute_set_in) begin
      txe_reg <= 1'b1;
      tx_data_reg <= shift_data_byte_in;
    end else if (take_tx) begin
      txe_reg <= 1'b0;
    end
  end

  // receive execute clears while bit six is fetched
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rxe_reg <= 1'b0;
    end else if (!module_enable_in) begin
      rxe_reg <= 1'b0;
    end else if (receive_execute_set_in) begin
      rxe_reg <= 1'b1;
    end else if (rxe_clear) begin
      rxe_reg <= 1'b0;
    end
  end

  // busy flags: fall at byte end; the wait state is entered only from idle flags
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      transmit_in_progress_reg <= 1'b0;
      rbusy_reg <= 1'b0;
    end else if (!module_enable_in) begin
      transmit_in_progress_reg <= 1'b0;
      rbusy_reg <= 1'b0;
    end else if (take_tx) begin
      transmit_in_progress_reg <= 1'b1;
    end else if (take_rx) begin
      rbusy_reg <= 1'b1;
    end else if (byte_done || go_wait) begin
      transmit_in_progress_reg <= 1'b0;
      rbusy_reg <= 1'b0;
    end
  end

  // ack status: the sampled answer wins over a software write in the same cycle
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_reg <= 1'b0;
    end else if (ack_sample) begin
      ack_reg <= sda_level;
    end else if (ack_status_write_in) begin
      ack_reg <= ack_status_in;
    end
  end

  // transmit buffer empty event, one cycle wide
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_empty_reg <= 1'b0;
    end else begin
      tx_empty_reg <= take_tx;
    end
  end

  // outputs; pins only ever pull low, the idle level comes from the pull-ups
  assign start_request_out = start_request_reg;
  assign stop_request_out = stp_reg;
  assign transmit_execute_out = txe_reg;
  assign receive_execute_out = rxe_reg;
  assign transmit_in_progress_out = transmit_in_progress_reg;
  assign receive_in_progress_out = rbusy_reg;
  assign ack_status_out = ack_reg;
  assign tx_buffer_empty_out = tx_empty_reg;
  assign bus_clock_level_out = filt_reg[i2c_master_pkg::PIN_SCL];
  assign bus_data_level_out = sda_level;
  assign sda_out = 1'b0;
  assign sda_oe_out = sda_low_reg;
  assign scl_out = 1'b0;
  assign scl_oe_out = scl_low_reg;

endmodule
`default_nettype wire

/* bench/i2c_master_start_transmit_monitor.sv */
// checker for the two-wire controller, watching its top-level ports only
// assumes one clock domain and the registered outputs described at hand-over
`timescale 1ns/1ns
`default_nettype none
module i2c_master_start_transmit_monitor (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // inputs watched
  input wire logic module_enable_in,
  input wire logic timer_tick_in,
  input wire logic ack_status_write_in,
  input wire logic rx_ready_in,
  // outputs watched
  input wire logic start_request_out,
  input wire logic stop_request_out,
  input wire logic transmit_execute_out,
  input wire logic transmit_in_progress_out,
  input wire logic ack_status_out,
  input wire logic tx_buffer_empty_out,
  input wire logic bus_data_level_out,
  input wire logic [7:0] rx_data_out,
  input wire logic rx_valid_out,
  input wire logic sda_oe_out,
  input wire logic scl_oe_out
);
  logic scl_oe_q;
  logic [3:0] rises;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);
  // counts clock releases inside one sent byte
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_oe_q <= 1'b0;
      rises <= 4'h0;
    end else begin
      scl_oe_q <= scl_oe_out;
      if (!transmit_in_progress_out) rises <= 4'h0;
      else if (scl_oe_q && !scl_oe_out) rises <= rises + 4'h1;
    end
  end
  a_scl_on_tick: assert property ($changed(scl_oe_out) && module_enable_in
    |-> $past(timer_tick_in))
    else $error("clock line moved without a tick");
  a_data_moves_low: assert property ($changed(sda_oe_out) && !scl_oe_out && module_enable_in |->
    $past(start_request_out) || $past(stop_request_out))
    else $error("data line moved while clock high");
  a_start_self_clear: assert property ($fell(start_request_out) && module_enable_in |->
    sda_oe_out && scl_oe_out)
    else $error("start request cleared early");
  a_stop_self_clear: assert property ($fell(stop_request_out) && module_enable_in |->
    !sda_oe_out && !scl_oe_out)
    else $error("stop request cleared before lines released");
  a_load_empty_event: assert property ($fell(transmit_execute_out) && module_enable_in |->
    transmit_in_progress_out ##[0:1] tx_buffer_empty_out)
    else $error("byte load without busy or empty event");
  a_empty_one_cycle: assert property (tx_buffer_empty_out |=> !tx_buffer_empty_out)
    else $error("empty event longer than one cycle");
  a_nine_clocks: assert property ($fell(transmit_in_progress_out) && module_enable_in |->
    rises == 4'h9 && scl_oe_out)
    else $error("byte did not take nine clocks");
  a_ack_from_line: assert property ($changed(ack_status_out) && !$past(ack_status_write_in) &&
    module_enable_in && $past(module_enable_in) |->
    transmit_in_progress_out && ack_status_out == $past(bus_data_level_out))
    else $error("ack status not taken from data line");
  a_disable_idle: assert property (!module_enable_in |=>
    !scl_oe_out && !sda_oe_out && !start_request_out && !transmit_in_progress_out)
    else $error("disabled controller not idle");
  a_rx_head_stable: assert property (rx_valid_out && !rx_ready_in && module_enable_in |=>
    rx_valid_out && $stable(rx_data_out))
    else $error("stalled receive head changed");
endmodule
bind i2c_master_start_transmit i2c_master_start_transmit_monitor
  i2c_master_start_transmit_monitor_inst (.*);
`default_nettype wire

/* bench/i2c_slave_model.sv */
// behavioural slave on the resolved wires: acks writes, serves reads, counts stops
// assumes pull-ups on both lines and a master that never stretches nor repeats start
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_model (
  // resolved bus wires
  input wire logic scl_in,
  input wire logic sda_in,
  // behaviour controls
  input wire logic nack_in,
  input wire logic [7:0] rd_base_in,
  // outputs
  output logic sda_oe_out,
  output logic [7:0] last_byte_out,
  output logic master_ack_out,
  output logic [3:0] stop_count_out
);
  logic [3:0] bit_cnt;
  logic [7:0] shift_reg;
  logic [7:0] rd_cnt;
  logic first;
  logic reading;
  logic [7:0] rd_byte;
  initial begin
    sda_oe_out = 1'b0;
    bit_cnt = 4'hF;
    rd_cnt = 8'h00;
    first = 1'b0;
    reading = 1'b0;
    stop_count_out = 4'h0;
    master_ack_out = 1'b1;
  end
  // a start opens a frame; the fall that follows it is not a bit
  // looked at 1 ns late: the master moves data in the step in which the clock falls
  always @(negedge sda_in) #1 if (scl_in === 1'b1) begin
    bit_cnt = 4'hF;
    first = 1'b1;
    reading = 1'b0;
    rd_cnt = 8'h00;
  end
  always @(posedge sda_in) #1 if (scl_in === 1'b1 && $time > 1) stop_count_out++;
  always @(posedge scl_in) begin
    if (bit_cnt < 4'h8) shift_reg = {shift_reg[6:0], sda_in};
    else master_ack_out = sda_in;
  end
  // the data line only moves while the clock is low
  always @(negedge scl_in) begin
    if (bit_cnt == 4'hF) bit_cnt = 4'h0;
    else if (bit_cnt == 4'h7) begin
      last_byte_out = shift_reg;
      if (first) reading = shift_reg[0];
      sda_oe_out = (first || !reading) && !nack_in;
      bit_cnt = 4'h8;
    end else if (bit_cnt == 4'h8) begin
      if (reading && !first) rd_cnt++;
      rd_byte = rd_base_in + rd_cnt;
      first = 1'b0;
      // a master refusal ends the read so the stop can be made
      reading = reading && !master_ack_out;
      sda_oe_out = reading && !rd_byte[7];
      bit_cnt = 4'h0;
    end else begin
      sda_oe_out = reading && !rd_byte[3'(6 - bit_cnt)];
      bit_cnt++;
    end
  end
endmodule
`default_nettype wire

/* bench/i2c_master_start_transmit_tb.sv */
// bench for the two-wire controller with a slave model on pulled-up wires
// assumes the package, interface, design, monitor and slave model compile first
`timescale 1ns/1ns
`default_nettype none
module i2c_master_start_transmit_tb;
  logic ref_clk_in, resetn_in, module_enable_in, noise_filter_on_in, timer_tick_in;
  logic [4:0] req;
  logic [7:0] shift_data_byte_in, rx_data_out, rd_base, got, addr, d1;
  logic ack_status_in, rx_ready_in, start_request_out, stop_request_out, transmit_execute_out;
  logic receive_execute_out, transmit_in_progress_out, receive_in_progress_out, ack_status_out;
  logic tx_buffer_empty_out, bus_clock_level_out, bus_data_level_out, rx_valid_out;
  logic sda_out, scl_out, sda_oe_out, scl_oe_out, slave_oe, nack, master_ack;
  logic [3:0] stops;
  logic [2:0] tick_cnt;
  int cycles, miscompares, checks_done;
  wire logic start_request_set_in = req[0];
  wire logic stop_request_set_in = req[1];
  wire logic transmit_execute_set_in = req[2];
  wire logic receive_execute_set_in = req[3];
  wire logic ack_status_write_in = req[4];
  wire logic scl_in = !scl_oe_out;
  wire logic sda_in = !(sda_oe_out || slave_oe);
  i2c_master_start_transmit i2c_master_start_transmit_inst (.*);
  i2c_slave_model i2c_slave_model_inst (.scl_in(scl_in), .sda_in(sda_in), .nack_in(nack),
    .rd_base_in(rd_base), .sda_oe_out(slave_oe), .last_byte_out(got),
    .master_ack_out(master_ack), .stop_count_out(stops));
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // one tick in eight cycles keeps the bit clock under a sixth of the clock
  always @(posedge ref_clk_in) begin
    tick_cnt <= tick_cnt + 3'h1;
    timer_tick_in <= (tick_cnt == 3'h7);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge ref_clk_in) req <= m;
    @(posedge ref_clk_in) req <= 5'h00;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return transmit_in_progress_out;
      1: return tx_buffer_empty_out;
      3: return stop_request_out;
      default: return receive_in_progress_out;
    endcase
  endfunction
  task automatic wait_lvl(input int s, input logic v);
    do cyc(); while (pick(s) !== v);
  endtask
  task automatic pop(input logic [7:0] exp);
    chk("received byte", rx_data_out, exp);
    rx_ready_in <= 1'b1;
    cyc();
    rx_ready_in <= 1'b0;
    cyc();
  endtask
  initial begin
    resetn_in = 1'b0;
    module_enable_in = 1'b0;
    noise_filter_on_in = 1'b1; // options set while disabled
    req = 5'h00;
    shift_data_byte_in = 8'h00;
    ack_status_in = 1'b0;
    rx_ready_in = 1'b0;
    nack = 1'b0;
    rd_base = 8'h00;
    tick_cnt = 3'h0;
    cycles = 0;
    miscompares = 0;
    checks_done = 0;
    void'($urandom(85));
    cyc(12);
    resetn_in <= 1'b1;
    cyc(6);
    chk("idle flags", {start_request_out, stop_request_out, transmit_execute_out, ack_status_out,
      receive_execute_out, transmit_in_progress_out, sda_oe_out, scl_oe_out}, 8'h00);
    chk("bus levels", {bus_clock_level_out, bus_data_level_out}, 8'h03);
    pulse(5'h01);
    cyc(2);
    chk("start while off", start_request_out, 1'b0);
    module_enable_in <= 1'b1;
    addr = {7'($urandom), 1'b0}; // one address byte, write direction
    d1 = 8'($urandom);
    shift_data_byte_in <= addr;
    pulse(5'h04); // byte and transmit before the start
    pulse(5'h01);
    wait_lvl(1, 1'b1);
    chk("txe after load", transmit_execute_out, 1'b0);
    shift_data_byte_in <= d1;
    pulse(5'h04); // queued behind the running byte
    wait_lvl(0, 1'b0);
    chk("address on wire", got, addr);
    chk("address ack", ack_status_out, 1'b0);
    nack <= 1'b1;
    wait_lvl(0, 1'b1);
    wait_lvl(0, 1'b0);
    chk("data on wire", got, d1);
    chk("data nack", ack_status_out, 1'b1);
    cyc(100);
    chk("wait holds clock", {scl_oe_out, transmit_in_progress_out}, 8'h02);
    pulse(5'h02);
    wait_lvl(3, 1'b0);
    chk("stop on wire", stops, 4'h1);
    chk("lines released", {sda_oe_out, scl_oe_out}, 8'h00);
    module_enable_in <= 1'b0;
    noise_filter_on_in <= 1'b0; // read runs unfiltered, set only while off
    cyc(2);
    module_enable_in <= 1'b1;
    nack <= 1'b0;
    rd_base <= 8'($urandom);
    shift_data_byte_in <= {7'($urandom), 1'b1}; // read direction after a stop
    pulse(5'h04);
    pulse(5'h01);
    wait_lvl(0, 1'b1);
    wait_lvl(0, 1'b0);
    ack_status_in <= 1'b0;
    pulse(5'h10);
    // receiver stalls so the buffer fills and the third byte must wait
    for (int i = 0; i < 3; i++) begin
      if (i == 2) begin
        ack_status_in <= 1'b1;
        pulse(5'h10);
      end
      pulse(5'h08);
      if (i < 2) begin
        wait_lvl(4, 1'b1);
        wait_lvl(4, 1'b0);
      end
    end
    cyc(200);
    chk("held while full", {receive_in_progress_out, receive_execute_out, rx_valid_out,
      scl_oe_out}, 8'h07);
    pop(rd_base);
    wait_lvl(4, 1'b1);
    wait_lvl(4, 1'b0);
    chk("master answer", master_ack, 1'b1);
    pop(rd_base + 8'h01);
    pop(rd_base + 8'h02);
    chk("drained", rx_valid_out, 1'b0);
    pulse(5'h02);
    wait_lvl(3, 1'b0);
    chk("second stop", stops, 4'h2);
    module_enable_in <= 1'b0; // disabled only after the stop
    cyc(3);
    chk("disabled", {sda_oe_out, scl_oe_out, start_request_out, sda_out, scl_out}, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
